// ### pkg/dgcs_params.svh
`ifndef DGCS_PARAMS_SVH
`define DGCS_PARAMS_SVH
// Register offsets
`define DGCS_OFS_GEN_CFG 8'h02
`define DGCS_OFS_REV 8'h03
`define DGCS_OFS_STATUS 8'h04
`define DGCS_OFS_PAR_HI 8'h05
`define DGCS_OFS_PAR_LO 8'h06
`define DGCS_OFS_WDOG 8'h07
// General configuration fields
`define DGCS_GC_PROXY_BIT 5
`define DGCS_GC_OUT_MODE_BIT 4
`define DGCS_GC_OUT_EN_BIT 3
`define DGCS_GC_SLEEP_SEL_BIT 2
`define DGCS_GC_PARITY_BIT 1
`define DGCS_GC_REF_FORCE_BIT 0
`define DGCS_GC_RESET 8'h1E
// Status fields
`define DGCS_ST_SUM_BIT 7
`define DGCS_ST_INIT_BIT 6
`define DGCS_ST_REF_BIT 4
`define DGCS_ST_PASS_BIT 3
`define DGCS_ST_LOCK_BIT 2
`define DGCS_ST_RSVD_LOW 2'h3
// Other reset values
`define DGCS_PAR_HI_RESET 8'h00
`define DGCS_PAR_LO_RESET 8'h00
`define DGCS_WDOG_RESET 8'h02
// Arbitrary identification values
`define DGCS_SILICON_REV 4'h5
`define DGCS_MASK_REV 4'h9
// Timing
`define DGCS_CLK_MHZ 100
`define DGCS_WDOG_STEP_MS 2
`define DGCS_WDOG_STEP_CYC (`DGCS_WDOG_STEP_MS * 1000 * `DGCS_CLK_MHZ)
`define DGCS_REF_WIN_CYC 1000
`define DGCS_REF_MIN_EDGES 120
`define DGCS_REF_MAX_EDGES 640
`endif

// ### pkg/dgcs_pkg.sv
package dgcs_pkg;
   // CSI transmit pin policy
   typedef enum logic [2:0] {
      DGCS_TX_NORMAL = 3'b001,
      DGCS_TX_HIZ = 3'b010,
      DGCS_TX_HS0 = 3'b100
   } dgcs_tx_state_t;

   // Register access request from either host path
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dgcs_req_t;

   // Watchdog states
   typedef enum logic [2:0] {
      DGCS_WD_IDLE = 3'b001,
      DGCS_WD_RUN = 3'b010,
      DGCS_WD_EXPIRE = 3'b100
   } dgcs_wd_state_t;
endpackage : dgcs_pkg

// ### hdl/dgcs_side_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
`include "dgcs_params.svh"
module dgcs_side_watchdog
   import dgcs_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Control
   input wire logic [6:0] i_steps,
   input wire logic i_disable,
   input wire logic i_busy,
   // Result
   output logic o_abort
);
   // ****************************************
   // Step divider and interval count
   // ****************************************
   localparam logic [27:0] STEP_LAST = 28'(`DGCS_WDOG_STEP_CYC - 1);
   dgcs_wd_state_t state, next_state;
   logic [27:0] div, next_div;
   logic [6:0] steps, next_steps;
   logic next_abort;

   always_comb
   begin
      next_state = state;
      next_div = div;
      next_steps = steps;
      next_abort = 1'b0;
      case (state)
         DGCS_WD_IDLE:
         begin
            next_div = 28'h000_0000;
            next_steps = 7'h00;
            if (i_busy && !i_disable)
               next_state = DGCS_WD_RUN;
         end
         DGCS_WD_RUN:
         begin
            if (!i_busy || i_disable)
               next_state = DGCS_WD_IDLE;
            else if (div == STEP_LAST)
            begin
               next_div = 28'h000_0000;
               next_steps = steps + 7'h01;
               // Zero steps is illegal; treated as one step rather than never
               if (steps + 7'h01 >= i_steps)
                  next_state = DGCS_WD_EXPIRE; // [R17]
            end
            else
               next_div = div + 28'h000_0001;
         end
         DGCS_WD_EXPIRE:
         begin
            // A disable landing on the expiry cycle still suppresses the pulse
            next_abort = !i_disable; // [R16] [R18]
            next_state = DGCS_WD_IDLE;
         end
         default: next_state = DGCS_WD_IDLE;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         state <= DGCS_WD_IDLE;
         div <= 28'h000_0000;
         steps <= 7'h00;
         o_abort <= 1'b0;
      end
      else
      begin
         state <= next_state;
         div <= next_div;
         steps <= next_steps;
         o_abort <= next_abort;
      end
   end

   AST_WD_OFF: assert property (@(posedge i_clock) disable iff (i_srst)
      i_disable |=> !o_abort) // [R18]
      else $error("Watchdog aborted while disabled");
endmodule : dgcs_side_watchdog
`default_nettype wire

// ### hdl/dgcs_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dgcs_params.svh"
//Function
//[R1] Proxy bus control for remote serializers allowed only when config bit 5 set.
//[R2] Mode bit 0 and no assigned lock: transmit port goes high impedance. Code drives HS-0 instead when sleep select is 0.
//[R3] Mode bit 1 and no lock: transmit port stays normal in LP-11. Code drives HS-0 instead when sleep select is 0.
//[R4] Sleep select 1 and output enable 0 force transmit outputs high impedance.
//[R5] Lock low with sleep select 0 drives transmit outputs in HS-0.
//[R6] Config bit 1 enables receive parity checker; enabled after reset.
//[R7] Config bit 0 forces reference clock reported present.
//[R8] Read-only revision register: silicon code 7:4, mask code 3:0.
//[R9] Status bit 7 set after init only with valid configuration checksum.
//[R10] Status bit 6 set once power-up initialization completes.
//[R11] Status bit 4 high only for reference frequency 12 to 64 MHz.
//[R12] Status bit 3 mirrors the pass output pin.
//[R13] Status bit 2 mirrors the lock output pin.
//[R14] Per port parity flag raised when error count reaches threshold.
//[R15] Threshold high byte gives bits 15:8, low byte bits 7:0.
//[R16] Control-channel transactions ended when watchdog interval runs out.
//[R17] Watchdog interval counts in 2 ms steps; zero must not be programmed.
//[R18] Watchdog disable bit stops the watchdog when set.
//[R19] Registers reachable from local I2C and from the control channel.
//[R20] Threshold compare uses current contents of both bytes.
//[R21] Writes to read-only registers ignored; reserved status bits read reset values.
module dgcs_top
   import dgcs_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Local I2C register access
   input wire dgcs_req_t i_i2c_req,
   output logic [7:0] o_i2c_rdata,
   // Control-channel register access
   input wire dgcs_req_t i_side_req,
   output logic [7:0] o_side_rdata,
   input wire logic i_side_busy,
   output logic o_side_abort,
   // Remote proxy request
   input wire logic i_proxy_req,
   output logic o_proxy_grant,
   // Initialization and reference clock
   input wire logic i_init_done,
   input wire logic i_init_sum_ok,
   input wire logic i_ref_clock_in,
   input wire logic i_ref_detect,
   // Receive ports
   input wire logic [1:0] i_port_lock,
   input wire logic [1:0] i_port_assigned,
   input wire logic [1:0] i_parity_err,
   input wire logic i_pass,
   // Outputs
   output logic o_lock,
   output logic o_pass,
   output logic o_parity_enable,
   output logic [1:0] o_parity_flag,
   output var dgcs_tx_state_t o_tx_state,
   output logic o_ref_present
);
   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] gen_cfg, next_gen_cfg;
   logic [7:0] par_hi, next_par_hi;
   logic [7:0] par_lo, next_par_lo;
   logic [7:0] wdog, next_wdog;
   logic [7:0] status;
   logic sum_ok, init_done, ref_good;

   // I2C write wins a same-cycle collision; the remote write is dropped
   always_comb
   begin
      next_gen_cfg = gen_cfg;
      next_par_hi = par_hi;
      next_par_lo = par_lo;
      next_wdog = wdog;
      for (int k = 0; k < 2; k++)
      begin
         dgcs_req_t r;
         r = (k == 0) ? i_side_req : i_i2c_req; // [R19]
         if (r.valid && r.write)
         begin
            // Read-only offsets fall through untouched
            case (r.addr) // [R21]
               `DGCS_OFS_GEN_CFG: next_gen_cfg = r.wdata;
               `DGCS_OFS_PAR_HI: next_par_hi = r.wdata;
               `DGCS_OFS_PAR_LO: next_par_lo = r.wdata;
               `DGCS_OFS_WDOG: next_wdog = r.wdata;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         gen_cfg <= `DGCS_GC_RESET; // [R6]
         par_hi <= `DGCS_PAR_HI_RESET;
         par_lo <= `DGCS_PAR_LO_RESET;
         wdog <= `DGCS_WDOG_RESET;
      end
      else
      begin
         gen_cfg <= next_gen_cfg;
         par_hi <= next_par_hi;
         par_lo <= next_par_lo;
         wdog <= next_wdog;
      end
   end

   // ****************************************
   // Status and read path
   // ****************************************
   always_comb
   begin
      status = 8'h00;
      status[`DGCS_ST_SUM_BIT] = sum_ok; // [R9]
      status[`DGCS_ST_INIT_BIT] = init_done; // [R10]
      status[`DGCS_ST_REF_BIT] = ref_good; // [R11]
      status[`DGCS_ST_PASS_BIT] = o_pass; // [R12]
      status[`DGCS_ST_LOCK_BIT] = o_lock; // [R13]
      status[1:0] = `DGCS_ST_RSVD_LOW; // [R21]
   end

   function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] st);
      case (a)
         `DGCS_OFS_GEN_CFG: read_reg = gen_cfg;
         `DGCS_OFS_REV: read_reg = {`DGCS_SILICON_REV, `DGCS_MASK_REV}; // [R8]
         `DGCS_OFS_STATUS: read_reg = st;
         `DGCS_OFS_PAR_HI: read_reg = par_hi;
         `DGCS_OFS_PAR_LO: read_reg = par_lo;
         `DGCS_OFS_WDOG: read_reg = wdog;
         default: read_reg = 8'h00;
      endcase
   endfunction : read_reg

   logic [7:0] next_i2c_rdata, next_side_rdata;
   always_comb
   begin
      next_i2c_rdata = o_i2c_rdata;
      next_side_rdata = o_side_rdata;
      if (i_i2c_req.valid && !i_i2c_req.write)
         next_i2c_rdata = read_reg(i_i2c_req.addr, status); // [R19]
      if (i_side_req.valid && !i_side_req.write)
         next_side_rdata = read_reg(i_side_req.addr, status); // [R19]
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         o_i2c_rdata <= 8'h00;
         o_side_rdata <= 8'h00;
      end
      else
      begin
         o_i2c_rdata <= next_i2c_rdata;
         o_side_rdata <= next_side_rdata;
      end
   end

   // ****************************************
   // Initialization, reference clock measure
   // ****************************************
   // Edge count over a fixed window; the pin is sampled, so only slow clocks are measurable
   logic ref_prev, next_ref_prev;
   logic [9:0] win, next_win;
   logic [9:0] edges, next_edges;
   logic next_sum_ok, next_init_done, next_ref_good;

   always_comb
   begin
      next_ref_prev = i_ref_clock_in;
      next_win = win + 10'h001;
      next_edges = edges + {9'h000, (i_ref_clock_in && !ref_prev)};
      next_ref_good = ref_good;
      next_init_done = init_done | i_init_done; // [R10]
      next_sum_ok = sum_ok;
      if (i_init_done && !init_done)
         next_sum_ok = i_init_sum_ok; // [R9]
      if (win == 10'(`DGCS_REF_WIN_CYC - 1))
      begin
         next_win = 10'h000;
         next_edges = 10'h000;
         next_ref_good = (edges >= 10'(`DGCS_REF_MIN_EDGES))
            && (edges <= 10'(`DGCS_REF_MAX_EDGES)); // [R11]
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         ref_prev <= 1'b0;
         win <= 10'h000;
         edges <= 10'h000;
         ref_good <= 1'b0;
         init_done <= 1'b0;
         sum_ok <= 1'b0;
      end
      else
      begin
         ref_prev <= next_ref_prev;
         win <= next_win;
         edges <= next_edges;
         ref_good <= next_ref_good;
         init_done <= next_init_done;
         sum_ok <= next_sum_ok;
      end
   end

   // ****************************************
   // Output policy, parity, proxy
   // ****************************************
   logic any_lock;
   dgcs_tx_state_t next_tx;
   logic [1:0] next_flag;
   logic [15:0] limit;
   logic [15:0] err_cnt [2];
   logic [15:0] next_cnt [2];

   always_comb
   begin
      any_lock = |(i_port_lock & i_port_assigned);
      limit = {par_hi, par_lo}; // [R15] [R20]
      if (!gen_cfg[`DGCS_GC_OUT_EN_BIT] && gen_cfg[`DGCS_GC_SLEEP_SEL_BIT])
         next_tx = DGCS_TX_HIZ; // [R4]
      else if (!any_lock && !gen_cfg[`DGCS_GC_SLEEP_SEL_BIT])
         next_tx = DGCS_TX_HS0; // [R5]
      else if (!any_lock && !gen_cfg[`DGCS_GC_OUT_MODE_BIT])
         next_tx = DGCS_TX_HIZ; // [R2]
      else
         next_tx = DGCS_TX_NORMAL; // [R3]
   end

   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_port
         always_comb
         begin
            next_cnt[p] = err_cnt[p];
            if (gen_cfg[`DGCS_GC_PARITY_BIT] && i_parity_err[p] && err_cnt[p] != 16'hFFFF)
               next_cnt[p] = err_cnt[p] + 16'h0001; // [R6]
            next_flag[p] = (err_cnt[p] >= limit); // [R14]
         end
         always_ff @(posedge i_clock)
         begin
            if (i_srst)
               err_cnt[p] <= 16'h0000;
            else
               err_cnt[p] <= next_cnt[p];
         end
      end
   endgenerate

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         o_tx_state <= DGCS_TX_HIZ;
         o_parity_flag <= 2'h0;
         o_lock <= 1'b0;
         o_pass <= 1'b0;
         o_parity_enable <= 1'b0;
         o_proxy_grant <= 1'b0;
         o_ref_present <= 1'b0;
      end
      else
      begin
         o_tx_state <= next_tx;
         o_parity_flag <= next_flag;
         o_lock <= any_lock;
         o_pass <= i_pass & any_lock;
         o_parity_enable <= gen_cfg[`DGCS_GC_PARITY_BIT]; // [R6]
         o_proxy_grant <= i_proxy_req & gen_cfg[`DGCS_GC_PROXY_BIT]; // [R1]
         o_ref_present <= gen_cfg[`DGCS_GC_REF_FORCE_BIT] | i_ref_detect; // [R7]
      end
   end

   dgcs_side_watchdog u_wdog (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_steps(wdog[7:1]), // [R17]
      .i_disable(wdog[0]), // [R18]
      .i_busy(i_side_busy),
      .o_abort(o_side_abort) // [R16]
   );

   // ****************************************
   // Checks
   // ****************************************
   AST_PROXY: assert property (@(posedge i_clock) disable iff (i_srst) // [R1]
      !gen_cfg[`DGCS_GC_PROXY_BIT] |=> !o_proxy_grant)
      else $error("Proxy granted while blocked");
   AST_HIZ_MODE: assert property (@(posedge i_clock) disable iff (i_srst) // [R2]
      (gen_cfg[4:2] == 3'b011 && !any_lock) |=> o_tx_state == DGCS_TX_HIZ)
      else $error("Transmit not high impedance without lock");
   AST_LP11: assert property (@(posedge i_clock) disable iff (i_srst) // [R3]
      (gen_cfg[4:2] == 3'b111 && !any_lock) |=> o_tx_state == DGCS_TX_NORMAL)
      else $error("Transmit left normal state");
   AST_FORCE_HIZ: assert property (@(posedge i_clock) disable iff (i_srst) // [R4]
      (gen_cfg[3:2] == 2'b01) |=> o_tx_state == DGCS_TX_HIZ)
      else $error("Output disable ignored");
   AST_HS0: assert property (@(posedge i_clock) disable iff (i_srst) // [R5]
      (!any_lock && !gen_cfg[2]) |=> o_tx_state == DGCS_TX_HS0)
      else $error("HS-0 not driven");
   AST_REF_FORCE: assert property (@(posedge i_clock) disable iff (i_srst) // [R7]
      gen_cfg[0] |=> o_ref_present)
      else $error("Forced reference not reported");
   AST_LOCK_MIRROR: assert property (@(posedge i_clock) disable iff (i_srst) // [R13]
      status[2] == o_lock && status[3] == o_pass)
      else $error("Status does not mirror pins");
   AST_PAR_FLAG: assert property (@(posedge i_clock) disable iff (i_srst) // [R14]
      (err_cnt[0] >= {par_hi, par_lo}) |=> o_parity_flag[0])
      else $error("Parity flag missing");
   AST_INIT_STICKY: assert property (@(posedge i_clock) disable iff (i_srst) // [R10]
      i_init_done |=> ##1 status[6])
      else $error("Init done not reported");
   AST_RO_WRITE: assert property (@(posedge i_clock) disable iff (i_srst) // [R21]
      (i_i2c_req.valid && i_i2c_req.write && i_i2c_req.addr == `DGCS_OFS_STATUS
         && !i_side_req.valid) |=> $stable(gen_cfg))
      else $error("Status write disturbed config");
   COV_HIZ: cover property (@(posedge i_clock) o_tx_state == DGCS_TX_HIZ);
   COV_FLAG: cover property (@(posedge i_clock) o_parity_flag[1]);
   COV_ABORT: cover property (@(posedge i_clock) o_side_abort);
endmodule : dgcs_top
`default_nettype wire

// ### tb/dgcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dgcs_host_model
   import dgcs_pkg::*;
(
   // Clock
   input wire logic i_clock,
   // Requests on both host paths
   output var dgcs_req_t o_i2c_req,
   output var dgcs_req_t o_side_req,
   // Read data
   input wire logic [7:0] i_i2c_rdata,
   input wire logic [7:0] i_side_rdata
);
   // ****************
   // Register access
   // ****************
   initial
   begin
      o_i2c_req = '0;
      o_side_req = '0;
   end

   // Held for one taking edge; idle fields inverted so stale values never match
   task automatic access(input logic side, input logic wr, input logic [7:0] addr,
      input logic [7:0] wdata, output logic [7:0] rdata);
      dgcs_req_t req;
      dgcs_req_t idle;
      req = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
      idle = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
      @(posedge i_clock);
      #1;
      if (side)
         o_side_req = req;
      else
         o_i2c_req = req;
      @(posedge i_clock);
      #1;
      o_i2c_req = idle;
      o_side_req = idle;
      @(posedge i_clock);
      #1;
      rdata = side ? i_side_rdata : i_i2c_rdata;
   endtask : access
endmodule : dgcs_host_model
`default_nettype wire

// ### tb/deser_global_config_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dgcs_params.svh"
module deser_global_config_status_tb;
   import dgcs_pkg::*;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   dgcs_req_t i2c_req;
   dgcs_req_t side_req;
   logic [7:0] i2c_rdata, side_rdata;
   logic side_abort, proxy_grant, lock_o, pass_o, par_en, ref_present;
   logic proxy_req = 1'b0, init_done = 1'b0, sum_ok = 1'b0, pass_in = 1'b0;
   logic ref_in = 1'b0, ref_detect = 1'b0, ref_run = 1'b0, side_busy = 1'b0;
   logic [1:0] port_lock = 2'b00, assigned = 2'b00, par_err = 2'b00, par_flag;
   dgcs_tx_state_t tx_state;
   int failures = 0, compares = 0, ref_cnt = 0, ref_half = 2;

   initial
   begin
      forever #5 i_clock = ~i_clock;
   end

   // Reference input toggled every ref_half cycles
   always @(posedge i_clock)
   begin
      #1;
      ref_cnt = ref_cnt + 1;
      if (ref_run && ref_cnt >= ref_half)
      begin
         ref_in = ~ref_in;
         ref_cnt = 0;
      end
   end

   dgcs_host_model i_host (.i_clock(i_clock), .o_i2c_req(i2c_req), .o_side_req(side_req),
      .i_i2c_rdata(i2c_rdata), .i_side_rdata(side_rdata));

   dgcs_top i_dut (.i_clock(i_clock), .i_srst(i_srst), .i_i2c_req(i2c_req),
      .o_i2c_rdata(i2c_rdata), .i_side_req(side_req), .o_side_rdata(side_rdata),
      .i_side_busy(side_busy), .o_side_abort(side_abort), .i_proxy_req(proxy_req),
      .o_proxy_grant(proxy_grant), .i_init_done(init_done), .i_init_sum_ok(sum_ok),
      .i_ref_clock_in(ref_in), .i_ref_detect(ref_detect), .i_port_lock(port_lock),
      .i_port_assigned(assigned), .i_parity_err(par_err), .i_pass(pass_in),
      .o_lock(lock_o), .o_pass(pass_o), .o_parity_enable(par_en),
      .o_parity_flag(par_flag), .o_tx_state(tx_state), .o_ref_present(ref_present));

   // ****************
   // Helpers
   // ****************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic settle;
      repeat (3) @(posedge i_clock);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      i_host.access(1'b0, 1'b1, a, d, x);
      settle;
   endtask : wr

   task automatic wr_side(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      i_host.access(1'b1, 1'b1, a, d, x);
      settle;
   endtask : wr_side

   task automatic rd_chk(input string name, input logic side, input logic [7:0] a,
      input logic [7:0] exp);
      logic [7:0] x;
      i_host.access(side, 1'b0, a, 8'h00, x);
      chk(name, exp, x);
   endtask : rd_chk

   task automatic do_reset;
      i_srst = 1'b1;
      repeat (5) @(posedge i_clock);
      #1;
      i_srst = 1'b0;
   endtask : do_reset

   task automatic pulse(input logic [1:0] m, input int n);
      repeat (n)
      begin
         @(posedge i_clock);
         #1;
         par_err = m;
         @(posedge i_clock);
         #1;
         par_err = 2'b00;
      end
      settle;
   endtask : pulse

   task automatic give_verdict;
      if (failures == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // ****************
   // Scenarios
   // ****************
   task automatic t_reset_values;
      rd_chk("gen_cfg", 1'b0, 8'h02, `DGCS_GC_RESET);
      rd_chk("revision", 1'b1, 8'h03, {`DGCS_SILICON_REV, `DGCS_MASK_REV});
      rd_chk("limit_high", 1'b0, 8'h05, `DGCS_PAR_HI_RESET);
      rd_chk("limit_low", 1'b1, 8'h06, 8'h00);
      rd_chk("watchdog", 1'b1, 8'h07, `DGCS_WDOG_RESET);
      rd_chk("unmapped", 1'b0, 8'h10, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h04, 8'hFF);
      rd_chk("revision", 1'b0, 8'h03, {`DGCS_SILICON_REV, `DGCS_MASK_REV});
      rd_chk("status", 1'b1, 8'h04, 8'h03);
      chk("parity_enable", 8'h01, {7'h00, par_en});
   endtask : t_reset_values

   task automatic t_init(input logic ok);
      sum_ok = ok;
      init_done = 1'b1;
      settle;
      rd_chk("status_init", 1'b0, 8'h04, {ok, 7'h43});
   endtask : t_init

   task automatic t_lock_pass;
      pass_in = 1'b1;
      port_lock = 2'b10;
      assigned = 2'b01;
      settle;
      chk("lock_pass", 8'h00, {6'h00, lock_o, pass_o});
      rd_chk("status_lp", 1'b0, 8'h04, 8'hC3);
      assigned = 2'b11;
      settle;
      chk("lock_pass", 8'h03, {6'h00, lock_o, pass_o});
      rd_chk("status_lp", 1'b1, 8'h04, 8'hCF);
      pass_in = 1'b0;
      settle;
      rd_chk("status_lp", 1'b0, 8'h04, 8'hC7);
   endtask : t_lock_pass

   task automatic t_tx_modes;
      logic [7:0] cfg [8] = '{8'h1E, 8'h0E, 8'h16, 8'h1A, 8'h0A, 8'h0E, 8'h16, 8'h1A};
      logic [1:0] lk [8] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b01, 2'b01};
      dgcs_tx_state_t ex [8] = '{DGCS_TX_NORMAL, DGCS_TX_HIZ, DGCS_TX_HIZ, DGCS_TX_HS0,
         DGCS_TX_HS0, DGCS_TX_NORMAL, DGCS_TX_HIZ, DGCS_TX_NORMAL};
      for (int i = 0; i < 8; i++)
      begin
         port_lock = lk[i];
         wr(8'h02, cfg[i]);
         chk("tx_state", {5'h00, ex[i]}, {5'h00, tx_state});
      end
      wr(8'h02, 8'h1E);
   endtask : t_tx_modes

   task automatic t_cfg_bits;
      proxy_req = 1'b1;
      wr(8'h02, 8'h3C);
      chk("cfg_outputs", 8'h04, {5'h00, proxy_grant, par_en, ref_present});
      // Checker off: a port 1 error must not reach the count
      pulse(2'b10, 1);
      chk("par_flag", 8'h01, {6'h00, par_flag});
      wr(8'h02, 8'h1F);
      chk("cfg_outputs", 8'h03, {5'h00, proxy_grant, par_en, ref_present});
      ref_detect = 1'b1;
      wr(8'h02, 8'h1E);
      chk("cfg_outputs", 8'h03, {5'h00, proxy_grant, par_en, ref_present});
      proxy_req = 1'b0;
      ref_detect = 1'b0;
      settle;
      chk("cfg_outputs", 8'h02, {5'h00, proxy_grant, par_en, ref_present});
   endtask : t_cfg_bits

   task automatic t_parity;
      chk("par_flag", 8'h03, {6'h00, par_flag});
      wr_side(8'h06, 8'h03);
      chk("par_flag", 8'h00, {6'h00, par_flag});
      pulse(2'b11, 2);
      chk("par_flag", 8'h00, {6'h00, par_flag});
      pulse(2'b01, 1);
      chk("par_flag", 8'h01, {6'h00, par_flag});
      wr(8'h05, 8'h01);
      chk("par_flag", 8'h00, {6'h00, par_flag});
      wr(8'h05, 8'h00);
      chk("par_flag", 8'h01, {6'h00, par_flag});
      rd_chk("limit_low", 1'b1, 8'h06, 8'h03);
   endtask : t_parity

   // One step lasts far longer than a run, so only early or disabled aborts are caught
   task automatic t_watchdog;
      logic seen;
      side_busy = 1'b1;
      for (int j = 0; j < 2; j++)
      begin
         seen = 1'b0;
         repeat (1500)
         begin
            @(posedge i_clock);
            #1;
            if (side_abort !== 1'b0)
               seen = 1'b1;
         end
         chk("side_abort", 8'h00, {7'h00, seen});
         wr_side(8'h07, 8'h03);
      end
      rd_chk("watchdog", 1'b0, 8'h07, 8'h03);
      side_busy = 1'b0;
   endtask : t_watchdog

   task automatic t_ref;
      port_lock = 2'b00;
      ref_half = 2;
      ref_run = 1'b1;
      repeat (2100) @(posedge i_clock);
      #1;
      rd_chk("ref_good", 1'b0, 8'h04, 8'hD3);
      ref_half = 16;
      repeat (2100) @(posedge i_clock);
      #1;
      rd_chk("ref_good", 1'b1, 8'h04, 8'hC3);
   endtask : t_ref

   initial
   begin
      #1_000_000;
      failures++;
      give_verdict;
   end

   initial
   begin
      do_reset;
      t_reset_values;
      t_init(1'b0);
      init_done = 1'b0;
      do_reset;
      t_init(1'b1);
      t_parity;
      t_lock_pass;
      t_tx_modes;
      t_cfg_bits;
      t_watchdog;
      t_ref;
      give_verdict;
   end
endmodule : deser_global_config_status_tb
`default_nettype wire
